// ---- bench/branch_control_executor_tb.sv ----
`timescale 1ns/100ps
`include "bce_map.svh"
module branch_control_executor_tb import bce_pkg::*; ;
    logic        clk = 1'b0, resetn = 1'b0, awValid = 1'b0, wValid = 1'b0, arValid = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0000_0000, rData, rv;
    logic [1:0]  bResp, rResp, rs, lastB;
    int          errors = 0, samples_checked = 0, cyc = 0;
    int lenT[29] = '{1,1,3,2,2,2,2,2,3,4,3,3,3,4,4,3,4,3,4,4,3,4,3,2,2,3,2,2,2};
    int fT[29] = '{2,4,6,6,6,6,6,6,8,11,8,9,10,10,11,8,11,10,10,12,8,12,10,6,6,8,4,6,6};
    int sT[29] = '{2,4,6,6,6,6,6,6,9,11,8,9,11,11,11,8,11,11,12,12,8,12,12,6,6,10,4,6,6};
    int pc, sp, status_word, g, m, d, f, tk, bt, k, x, s, y, el, lim;
    bce_executor #(.ADDR_W(8)) dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(1'b1), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1));
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // each channel released only at its own handshake edge
    task automatic wr(input logic [7:0] ad, input logic [31:0] dv);
        int t;
        t = 0;
        awAddr <= ad;
        wData <= dv;
        awValid <= 1'b1;
        wValid <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (awValid && awReady === 1'b1) awValid <= 1'b0;
            if (wValid && wReady === 1'b1) wValid <= 1'b0;
        end while (bValid !== 1'b1 && t < 40);
        lastB = bResp;
        // a missing write answer counts as a mismatch
        chk("bvalid", 1, bValid);
    endtask
    task automatic rd(input logic [7:0] ad);
        int t;
        t = 0;
        arAddr <= ad;
        arValid <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (arValid && arReady === 1'b1) arValid <= 1'b0;
        end while (rValid !== 1'b1 && t < 40);
        rv = rData;
        rs = rResp;
        chk("rvalid", 1, rValid);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic run(input int op, input bit rf);
        pc = $urandom & 16'hFFFF;
        sp = $urandom & 16'hFFFF;
        status_word = $urandom & 8'hFF;
        g = $urandom & 24'hFF_FFFF;
        m = $urandom & 24'hFF_FFFF;
        d = $urandom;
        f = $urandom & 11'h7E0;
        // loop counters near zero half the time
        if ($urandom % 2) g = (g & 8'hFF) | 24'h01_0100;
        if ($urandom % 2) m = (m & 24'hFF_FF00) | 1;
        wr(`BCE_A_PC, pc);
        wr(`BCE_A_SP, sp);
        wr(`BCE_A_PSW, status_word);
        wr(`BCE_A_GPR, g);
        wr(`BCE_A_MEM, m);
        wr(`BCE_A_OPND, d);
        wr(`BCE_A_CMD, f | op);
        el = cyc;
        // write while busy must be dropped
        if (rf) wr(`BCE_A_PC, 16'h1234);
        do rd(`BCE_A_STAT); while (rv[0] !== 1'b0 && cyc - el < 60);
        el = cyc - el;
        lim = f[10] ? fT[op] : sT[op];
        bt = (f >> 5) & 7;
        k = (op + 2) % 5;
        x = k == 2 ? g & 8'hFF : k == 3 ? status_word : m & 8'hFF;
        tk = 0;
        case (op)
            1: sp = (sp + 2) & 16'hFFFF;
            2, 3: tk = 1;
            4, 5: tk = (status_word & 1) == 5 - op;
            6, 7: tk = ((status_word >> 6) & 1) == 7 - op;
            23, 24, 25: begin
                s = op == 23 ? 8 : op == 24 ? 16 : 0;
                y = (((op == 25 ? m : g) >> s) - 1) & 8'hFF;
                if (op == 25) m = (m & 24'hFF_FF00) | y;
                else g = (g & ~(8'hFF << s)) | (y << s);
                tk = y != 0;
            end
            26: status_word = (status_word & 8'hD7) | (f[9] << 5) | (f[8] << 3);
            27: status_word = status_word | 8'h80;
            28: status_word = status_word & 8'h7F;
            default: if (op >= 8) begin
                tk = ((x >> bt) & 1) == (op < 13 || op > 17);
                if (tk && op > 17 && k == 2) g = g & ~(1 << bt);
                if (tk && op > 17 && k == 3) status_word = status_word & ~(1 << bt);
                if (tk && op > 17 && k != 2 && k != 3) m = m & ~(1 << bt);
            end
        endcase
        pc = op == 2 ? d >> 16 : pc + lenT[op] + (tk ? (d & 8'hFF) - ((d & 8'h80) << 1) : 0);
        // status is polled every other edge, so idle shows one or two edges late
        chk("clocks", 1, el > lim && el <= lim + 2);
        chk("taken", tk, rv[1]);
        if (op == 1) chk("pair", m >> 8, rv[31:16]);
        rd(`BCE_A_PC);
        chk("pc", pc & 16'hFFFF, rv & 16'hFFFF);
        rd(`BCE_A_SP);
        chk("sp", sp, rv & 16'hFFFF);
        rd(`BCE_A_PSW);
        chk("psw", status_word, rv & 8'hFF);
        rd(`BCE_A_GPR);
        chk("gpr", g, rv & 24'hFF_FFFF);
        rd(`BCE_A_MEM);
        chk("mem", m, rv & 24'hFF_FFFF);
        $display("test op %0d done", op);
    endtask
    initial begin
        void'($urandom(27));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(`BCE_A_SP);
        chk("sp_reset", `BCE_RST_SP, rv & 16'hFFFF);
        rd(`BCE_A_PSW);
        chk("psw_reset", `BCE_RST_PSW, rv & 8'hFF);
        wr(8'h20, 32'h0000_0001);
        chk("bresp", `BCE_RESP_DEC, lastB);
        rd(8'h22);
        chk("rresp", `BCE_RESP_DEC, rs);
        chk("rdata", 0, rv);
        $display("test reset and bus done");
        for (int i = 0; i < 29; i++) run(i, 1'b0);
        run(3, 1'b1);
        repeat (60) run($urandom % 29, 1'b0);
        print_verdict;
    end
    // no hang may outlast the planned run
    initial begin
        #(40 * 30000);
        errors++;
        print_verdict;
    end
endmodule // branch_control_executor_tb

// ---- hdl/bce_executor.sv ----
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "bce_map.svh"

// What this block does
// - A pair pop takes its high byte from one above the stack pointer, its low byte at it, then adds two.
// - The relative jump loads the next address plus the sign-extended offset and takes six clocks.
// - Carry branches go when carry is 1 or 0 respectively, else fall through, two bytes, six clocks.
// - Zero branches go when zero is 1 or 0 respectively, else fall through, six clocks.
// - Bit-set branch on a short-direct bit is three bytes and takes 8 clocks on fast RAM, else 9.
// - Bit-set branch on a special-function bit is four bytes and takes 11 clocks.
// - Bit-clear branch on a short-direct bit is four bytes and takes 10 or 11 clocks.
// - Bit-clear branch on the pointer-addressed memory bit is three bytes long.
// - Set-then-clear branch clears the bit and jumps only when it is 1; accumulator form 3 bytes, 8 clocks.
// - Set-then-clear on a status-word bit may alter zero, aux carry and carry; 4 bytes, 12 clocks.
// - Loop on B or C decrements first, then jumps by pc plus 2 when the result is nonzero; six clocks.
// - Loop on a short-direct byte writes the decrement back and jumps by pc plus 3 if nonzero; 8 or 10.
// - Each counted clock is exactly one period of the selected core clock.
// - Counts are those for fetching from internal program memory.
module bce_executor
    import bce_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    bce_cpu_t          cpu_r,    cpu_nxt;
    bce_op_t           op_r,     op_nxt;
    logic [2:0]        bit_r,    bit_nxt;
    logic [1:0]        bank_r,   bank_nxt;
    logic              fast_r,   fast_nxt;
    logic [31:0]       opnd_r,   opnd_nxt;
    logic              busy_r,   busy_nxt;
    logic [3:0]        cnt_r,    cnt_nxt;
    logic [3:0]        runLen_r, runLen_nxt;
    logic              taken_r,  taken_nxt;
    logic [15:0]       popRp_r,  popRp_nxt;
    logic [ADDR_W-1:0] wAddr_r,  wAddr_nxt;
    logic [31:0]       wData_r,  wData_nxt;
    logic [3:0]        wStrb_r,  wStrb_nxt;
    logic              awRdy_r,  awRdy_nxt;
    logic              wRdy_r,   wRdy_nxt;
    logic              bVal_r,   bVal_nxt;
    logic [1:0]        bResp_r,  bResp_nxt;
    logic              arRdy_r,  arRdy_nxt;
    logic              rVal_r,   rVal_nxt;
    logic [31:0]       rData_r,  rData_nxt;
    logic [1:0]        rResp_r,  rResp_nxt;

    bce_tim_t    tim;
    bce_tim_t    newTim;
    bce_op_t     newOp;
    logic [7:0]  srcByte;
    logic        testBit;
    logic [15:0] nextPc;
    logic [15:0] target;
    logic [7:0]  decByte;
    logic [31:0] oldWord;
    logic [31:0] merged;
    logic        wrFire;
    logic        fin;

    // per-op length and clocks; fast applies to internal high-speed RAM
    function automatic bce_tim_t timOf(input bce_op_t o);
        timOf = '{`BCE_LEN1, `BCE_CLK2, `BCE_CLK2};
        unique case (o)
            OP_NOP:      timOf = '{`BCE_LEN1, `BCE_CLK2, `BCE_CLK2};
            OP_POP:      timOf = '{`BCE_LEN1, `BCE_CLK4, `BCE_CLK4};
            OP_BR_ABS:   timOf = '{`BCE_LEN3, `BCE_CLK6, `BCE_CLK6};
            OP_BR_REL, OP_BC, OP_BNC, OP_BZ, OP_BNZ, OP_DB_B, OP_DB_C:
                         timOf = '{`BCE_LEN2, `BCE_CLK6, `BCE_CLK6};
            OP_BT_SADDR: timOf = '{`BCE_LEN3, `BCE_CLK8, `BCE_CLK9};
            OP_BT_SFR:   timOf = '{`BCE_LEN4, `BCE_CLK11, `BCE_CLK11};
            OP_BT_A, OP_BF_A, OP_BX_A:
                         timOf = '{`BCE_LEN3, `BCE_CLK8, `BCE_CLK8};
            OP_BT_PSW:   timOf = '{`BCE_LEN3, `BCE_CLK9, `BCE_CLK9};
            OP_BT_HL, OP_BF_HL:
                         timOf = '{`BCE_LEN3, `BCE_CLK10, `BCE_CLK11};
            OP_BF_SADDR: timOf = '{`BCE_LEN4, `BCE_CLK10, `BCE_CLK11};
            OP_BF_SFR, OP_BF_PSW:
                         timOf = '{`BCE_LEN4, `BCE_CLK11, `BCE_CLK11};
            OP_BX_SADDR: timOf = '{`BCE_LEN4, `BCE_CLK10, `BCE_CLK12};
            OP_BX_SFR, OP_BX_PSW:
                         timOf = '{`BCE_LEN4, `BCE_CLK12, `BCE_CLK12};
            OP_BX_HL:    timOf = '{`BCE_LEN3, `BCE_CLK10, `BCE_CLK12};
            OP_DB_SADDR: timOf = '{`BCE_LEN3, `BCE_CLK8, `BCE_CLK10};
            OP_SEL:      timOf = '{`BCE_LEN2, `BCE_CLK4, `BCE_CLK4};
            OP_EI, OP_DI:
                         timOf = '{`BCE_LEN2, `BCE_CLK6, `BCE_CLK6};
        endcase
    endfunction

    function automatic logic [31:0] readOf(input logic [ADDR_W-1:0] ad, input bce_cpu_t cp,
                                           input logic [31:0] od, input logic bz,
                                           input logic tk, input logic [15:0] rp);
        readOf = 32'h0000_0000;
        unique case (ad)
            `BCE_A_CMD:  readOf = 32'h0000_0000;
            `BCE_A_OPND: readOf = od;
            `BCE_A_PC:   readOf = {16'h0000, cp.pc};
            `BCE_A_SP:   readOf = {16'h0000, cp.sp};
            `BCE_A_PSW:  readOf = {24'h00_0000, cp.status_word};
            `BCE_A_GPR:  readOf = {8'h00, cp.c, cp.b, cp.a};
            `BCE_A_MEM:  readOf = {8'h00, cp.stkHi, cp.stkLo, cp.opnd};
            `BCE_A_STAT: readOf = {rp, 14'h0000, tk, bz};
            default:     readOf = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] ad);
        mapped = (ad[1:0] == 2'b00) && (ad <= `BCE_A_STAT);
    endfunction

    always_comb begin
        cpu_nxt    = cpu_r;
        op_nxt     = op_r;
        bit_nxt    = bit_r;
        bank_nxt   = bank_r;
        fast_nxt   = fast_r;
        opnd_nxt   = opnd_r;
        busy_nxt   = busy_r;
        cnt_nxt    = cnt_r;
        runLen_nxt = busy_r ? runLen_r + 4'h1 : 4'h0;
        taken_nxt  = taken_r;
        popRp_nxt  = popRp_r;
        wAddr_nxt  = wAddr_r;
        wData_nxt  = wData_r;
        wStrb_nxt  = wStrb_r;
        awRdy_nxt  = awRdy_r;
        wRdy_nxt   = wRdy_r;
        bVal_nxt   = bVal_r;
        bResp_nxt  = bResp_r;
        arRdy_nxt  = arRdy_r;
        rVal_nxt   = rVal_r;
        rData_nxt  = rData_r;
        rResp_nxt  = rResp_r;

        tim = timOf(op_r);
        unique case (op_r)
            OP_BT_A, OP_BF_A, OP_BX_A:       srcByte = cpu_r.a;
            OP_BT_PSW, OP_BF_PSW, OP_BX_PSW: srcByte = cpu_r.status_word;
            default:                         srcByte = cpu_r.opnd;
        endcase
        testBit = srcByte[bit_r];
        nextPc  = cpu_r.pc + tim.len;
        target  = nextPc + {{8{opnd_r[7]}}, opnd_r[`BCE_F_DISP]};
        decByte = 8'h00;
        fin     = busy_r && (cnt_r == 4'h0);

        // address and data are taken in either order; response once both are held
        if (s_axi_awvalid && awRdy_r) begin
            wAddr_nxt = s_axi_awaddr;
            awRdy_nxt = 1'b0;
        end
        if (s_axi_wvalid && wRdy_r) begin
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
            wRdy_nxt  = 1'b0;
        end
        if (bVal_r && s_axi_bready) begin
            bVal_nxt  = 1'b0;
            awRdy_nxt = 1'b1;
            wRdy_nxt  = 1'b1;
        end
        wrFire  = !awRdy_r && !wRdy_r && !bVal_r;
        oldWord = readOf(wAddr_r, cpu_r, opnd_r, busy_r, taken_r, popRp_r);
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = wStrb_r[i] ? wData_r[i*8 +: 8] : oldWord[i*8 +: 8];
        end
        newOp  = (merged[`BCE_F_OP] > `BCE_OP_LAST) ? OP_NOP : bce_op_t'(merged[`BCE_F_OP]);
        newTim = timOf(newOp);

        if (wrFire) begin
            bVal_nxt  = 1'b1;
            bResp_nxt = mapped(wAddr_r) ? `BCE_RESP_OK : `BCE_RESP_DEC;
            // state is frozen while an instruction runs; such writes are dropped
            if (!busy_r) begin
                unique case (wAddr_r)
                    `BCE_A_CMD: begin
                        op_nxt   = newOp;
                        bit_nxt  = merged[`BCE_F_BIT];
                        bank_nxt = merged[`BCE_F_BANK];
                        fast_nxt = merged[`BCE_F_FAST];
                        busy_nxt = 1'b1;
                        cnt_nxt  = (merged[`BCE_F_FAST] ? newTim.fast : newTim.slow) - 4'h1;
                    end
                    `BCE_A_OPND: opnd_nxt = merged;
                    `BCE_A_PC:   cpu_nxt.pc = merged[15:0];
                    `BCE_A_SP:   cpu_nxt.sp = merged[15:0];
                    `BCE_A_PSW:  cpu_nxt.status_word = merged[7:0];
                    `BCE_A_GPR:  {cpu_nxt.c, cpu_nxt.b, cpu_nxt.a} = merged[23:0];
                    `BCE_A_MEM:  {cpu_nxt.stkHi, cpu_nxt.stkLo, cpu_nxt.opnd} = merged[23:0];
                    default: ;
                endcase
            end
        end

        if (busy_r && !fin) begin
            cnt_nxt = cnt_r - 4'h1;
        end
        if (fin) begin
            busy_nxt   = 1'b0;
            taken_nxt  = 1'b0;
            cpu_nxt.pc = nextPc;
            unique case (op_r)
                OP_NOP: ;
                OP_POP: begin
                    popRp_nxt  = {cpu_r.stkHi, cpu_r.stkLo};
                    cpu_nxt.sp = cpu_r.sp + `BCE_SP_STEP;
                end
                OP_BR_ABS: begin
                    cpu_nxt.pc = opnd_r[`BCE_F_ABS];
                    taken_nxt  = 1'b1;
                end
                OP_BR_REL: begin
                    cpu_nxt.pc = target;
                    taken_nxt  = 1'b1;
                end
                OP_BC, OP_BNC: begin
                    if (cpu_r.status_word[`BCE_PSW_CY] == (op_r == OP_BC)) begin
                        cpu_nxt.pc = target;
                        taken_nxt  = 1'b1;
                    end
                end
                OP_BZ, OP_BNZ: begin
                    if (cpu_r.status_word[`BCE_PSW_Z] == (op_r == OP_BZ)) begin
                        cpu_nxt.pc = target;
                        taken_nxt  = 1'b1;
                    end
                end
                OP_BT_SADDR, OP_BT_SFR, OP_BT_A, OP_BT_PSW, OP_BT_HL: begin
                    if (testBit) begin
                        cpu_nxt.pc = target;
                        taken_nxt  = 1'b1;
                    end
                end
                OP_BF_SADDR, OP_BF_SFR, OP_BF_A, OP_BF_PSW, OP_BF_HL: begin
                    if (!testBit) begin
                        cpu_nxt.pc = target;
                        taken_nxt  = 1'b1;
                    end
                end
                OP_BX_SADDR, OP_BX_SFR, OP_BX_A, OP_BX_PSW, OP_BX_HL: begin
                    if (testBit) begin
                        cpu_nxt.pc = target;
                        taken_nxt  = 1'b1;
                        unique case (op_r)
                            OP_BX_A:   cpu_nxt.a[bit_r] = 1'b0;
                            OP_BX_PSW: cpu_nxt.status_word[bit_r] = 1'b0;
                            default:   cpu_nxt.opnd[bit_r] = 1'b0;
                        endcase
                    end
                end
                OP_DB_B, OP_DB_C, OP_DB_SADDR: begin
                    unique case (op_r)
                        OP_DB_B: begin
                            decByte   = cpu_r.b - 8'h01;
                            cpu_nxt.b = decByte;
                        end
                        OP_DB_C: begin
                            decByte   = cpu_r.c - 8'h01;
                            cpu_nxt.c = decByte;
                        end
                        default: begin
                            decByte      = cpu_r.opnd - 8'h01;
                            cpu_nxt.opnd = decByte;
                        end
                    endcase
                    if (decByte != 8'h00) begin
                        cpu_nxt.pc = target;
                        taken_nxt  = 1'b1;
                    end
                end
                OP_SEL: {cpu_nxt.status_word[`BCE_PSW_BANK_SELECT_BITS], cpu_nxt.status_word[`BCE_PSW_RBS0]} = bank_r;
                OP_EI: cpu_nxt.status_word[`BCE_PSW_IE] = 1'b1;
                OP_DI: cpu_nxt.status_word[`BCE_PSW_IE] = 1'b0;
            endcase
        end

        if (s_axi_arvalid && arRdy_r) begin
            arRdy_nxt = 1'b0;
            rVal_nxt  = 1'b1;
            rData_nxt = readOf(s_axi_araddr, cpu_r, opnd_r, busy_r, taken_r, popRp_r);
            rResp_nxt = mapped(s_axi_araddr) ? `BCE_RESP_OK : `BCE_RESP_DEC;
        end
        if (rVal_r && s_axi_rready) begin
            rVal_nxt  = 1'b0;
            arRdy_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cpu_r    <= '{pc: 16'h0000, sp: `BCE_RST_SP, status_word: `BCE_RST_PSW, default: 8'h00};
            op_r     <= OP_NOP;
            bit_r    <= 3'h0;
            bank_r   <= 2'h0;
            fast_r   <= 1'b0;
            opnd_r   <= 32'h0000_0000;
            busy_r   <= 1'b0;
            cnt_r    <= 4'h0;
            runLen_r <= 4'h0;
            taken_r  <= 1'b0;
            popRp_r  <= 16'h0000;
            wAddr_r  <= '0;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            awRdy_r  <= 1'b1;
            wRdy_r   <= 1'b1;
            bVal_r   <= 1'b0;
            bResp_r  <= `BCE_RESP_OK;
            arRdy_r  <= 1'b1;
            rVal_r   <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= `BCE_RESP_OK;
        end else begin
            cpu_r    <= cpu_nxt;
            op_r     <= op_nxt;
            bit_r    <= bit_nxt;
            bank_r   <= bank_nxt;
            fast_r   <= fast_nxt;
            opnd_r   <= opnd_nxt;
            busy_r   <= busy_nxt;
            cnt_r    <= cnt_nxt;
            runLen_r <= runLen_nxt;
            taken_r  <= taken_nxt;
            popRp_r  <= popRp_nxt;
            wAddr_r  <= wAddr_nxt;
            wData_r  <= wData_nxt;
            wStrb_r  <= wStrb_nxt;
            awRdy_r  <= awRdy_nxt;
            wRdy_r   <= wRdy_nxt;
            bVal_r   <= bVal_nxt;
            bResp_r  <= bResp_nxt;
            arRdy_r  <= arRdy_nxt;
            rVal_r   <= rVal_nxt;
            rData_r  <= rData_nxt;
            rResp_r  <= rResp_nxt;
        end
    end

    assign s_axi_awready = awRdy_r;
    assign s_axi_wready  = wRdy_r;
    assign s_axi_bvalid  = bVal_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = arRdy_r;
    assign s_axi_rvalid  = rVal_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;

    pop_pair_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_POP |=> cpu_r.sp == $past(cpu_r.sp) + `BCE_SP_STEP
            && popRp_r == {$past(cpu_r.stkHi), $past(cpu_r.stkLo)})
        else $error("pop pair wrong");
    rel_jump_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_BR_REL |=> cpu_r.pc == $past(cpu_r.pc) + `BCE_LEN2
            + {{8{$past(opnd_r[7])}}, $past(opnd_r[7:0])})
        else $error("relative jump target wrong");
    carry_fall_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_BC && !cpu_r.status_word[`BCE_PSW_CY] |=> cpu_r.pc == $past(cpu_r.pc) + `BCE_LEN2 && !taken_r)
        else $error("carry branch taken without carry");
    zero_fall_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_BNZ && cpu_r.status_word[`BCE_PSW_Z] |=> cpu_r.pc == $past(cpu_r.pc) + `BCE_LEN2)
        else $error("nonzero branch taken on zero");
    bit_run_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(busy_r) && op_r == OP_BT_SADDR && fast_r |-> busy_r [*8] ##1 !busy_r)
        else $error("bit test run length wrong");
    clock_count_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(busy_r) |-> runLen_r == (fast_r ? tim.fast : tim.slow))
        else $error("instruction clock count wrong");
    clear_set_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_BX_A && cpu_r.a[bit_r] |=> !cpu_r.a[$past(bit_r)] && taken_r)
        else $error("set-then-clear did not clear");
    loop_dec_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_DB_B |=> cpu_r.b == $past(cpu_r.b) - 8'h01 && taken_r == (cpu_r.b != 8'h00))
        else $error("loop decrement wrong");
    irq_en_a: assert property (@(posedge clk) disable iff (!resetn)
        fin && op_r == OP_EI |=> cpu_r.status_word[`BCE_PSW_IE])
        else $error("enable flag not set");
endmodule // bce_executor

// ---- hdl/bce_map.svh ----
`ifndef BCE_MAP_SVH
`define BCE_MAP_SVH
// register byte offsets
`define BCE_A_CMD    8'h00
`define BCE_A_OPND   8'h04
`define BCE_A_PC     8'h08
`define BCE_A_SP     8'h0C
`define BCE_A_PSW    8'h10
`define BCE_A_GPR    8'h14
`define BCE_A_MEM    8'h18
`define BCE_A_STAT   8'h1C
// command and operand fields
`define BCE_F_OP     4:0
`define BCE_F_BIT    7:5
`define BCE_F_BANK   9:8
`define BCE_F_FAST   10
`define BCE_F_DISP   7:0
`define BCE_F_ABS    31:16
`define BCE_OP_LAST  5'h1C
// status word bits
`define BCE_PSW_IE   7
`define BCE_PSW_Z    6
`define BCE_PSW_BANK_SELECT_BITS 5
`define BCE_PSW_AC   4
`define BCE_PSW_RBS0 3
`define BCE_PSW_CY   0
// reset values
`define BCE_RST_SP   16'hFF00
`define BCE_RST_PSW  8'h02
// instruction lengths, clock counts, stack step and bus response codes
`define BCE_LEN1     16'h0001
`define BCE_LEN2     16'h0002
`define BCE_LEN3     16'h0003
`define BCE_LEN4     16'h0004
`define BCE_CLK2     4'h2
`define BCE_CLK4     4'h4
`define BCE_CLK6     4'h6
`define BCE_CLK8     4'h8
`define BCE_CLK9     4'h9
`define BCE_CLK10    4'hA
`define BCE_CLK11    4'hB
`define BCE_CLK12    4'hC
`define BCE_SP_STEP  16'h0002
`define BCE_RESP_OK  2'b00
`define BCE_RESP_DEC 2'b11
`endif

// ---- hdl/bce_pkg.sv ----
package bce_pkg;
    typedef enum logic [4:0] {
        OP_NOP      = 5'b00000, OP_POP      = 5'b00001, OP_BR_ABS   = 5'b00010,
        OP_BR_REL   = 5'b00011, OP_BC       = 5'b00100, OP_BNC      = 5'b00101,
        OP_BZ       = 5'b00110, OP_BNZ      = 5'b00111, OP_BT_SADDR = 5'b01000,
        OP_BT_SFR   = 5'b01001, OP_BT_A     = 5'b01010, OP_BT_PSW   = 5'b01011,
        OP_BT_HL    = 5'b01100, OP_BF_SADDR = 5'b01101, OP_BF_SFR   = 5'b01110,
        OP_BF_A     = 5'b01111, OP_BF_PSW   = 5'b10000, OP_BF_HL    = 5'b10001,
        OP_BX_SADDR = 5'b10010, OP_BX_SFR   = 5'b10011, OP_BX_A     = 5'b10100,
        OP_BX_PSW   = 5'b10101, OP_BX_HL    = 5'b10110, OP_DB_B     = 5'b10111,
        OP_DB_C     = 5'b11000, OP_DB_SADDR = 5'b11001, OP_SEL      = 5'b11010,
        OP_EI       = 5'b11011, OP_DI       = 5'b11100
    } bce_op_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  status_word;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  c;
        logic [7:0]  opnd;
        logic [7:0]  stkLo;
        logic [7:0]  stkHi;
    } bce_cpu_t;

    typedef struct packed {
        logic [15:0] len;
        logic [3:0]  fast;
        logic [3:0]  slow;
    } bce_tim_t;
endpackage
